// >>> dasq_pkg.sv
// constants, field layouts and carrier types of the display address sequencer
// assumes one character clock (hclk) drives the whole block
package dasq_pkg;

  localparam int unsigned ADDR_W = 14; // display address bus width

  // register byte offsets on the bus
  localparam logic [7:0] REG_FIRST_LO = 8'h00; // buffer_first_address_low
  localparam logic [7:0] REG_BOUNDS   = 8'h04; // buffer_bounds_high
  localparam logic [7:0] REG_BLINK_SP = 8'h08; // cursor_blink_split_row
  localparam logic [7:0] REG_CONFIG   = 8'h0C; // raster and cursor config
  localparam logic [7:0] REG_SCREEN   = 8'h10; // screen start address
  localparam logic [7:0] REG_CURSOR   = 8'h14; // cursor address
  localparam logic [7:0] REG_POINTER  = 8'h18; // pointer address
  localparam logic [7:0] REG_COMMAND  = 8'h1C; // command strobes
  localparam logic [7:0] REG_STATUS   = 8'h20; // status, bit 0 write-1-clear
  localparam logic [7:0] REG_ADDRMON  = 8'h24; // counter and latch monitor

  // field positions
  localparam int unsigned CFG_ACT_LSB   = 0;
  localparam int unsigned CFG_LINES_LSB = 8;
  localparam int unsigned CFG_ROWS_LSB  = 16;
  localparam int unsigned CFG_BLINK_EN  = 24;
  localparam int unsigned CFG_CUR_EN    = 25;
  localparam int unsigned CFG_SPLIT_MSK = 26;
  localparam int unsigned BSP_RATE      = 7;
  localparam int unsigned CMD_CUR_INC   = 0;
  localparam int unsigned ST_SPLIT      = 0;
  localparam int unsigned ST_VBLANK     = 1;
  localparam int unsigned ST_ROW_LSB    = 8;
  localparam int unsigned MON_RSR_LSB   = 16;

  // values after reset
  localparam logic [7:0] RST_ACT   = 8'h50;
  localparam logic [3:0] RST_LINES = 4'hB;
  localparam logic [6:0] RST_ROWS  = 7'h17;

  // default blanking counts in character clocks and scan lines
  localparam int unsigned HBLANK_CHARS_DEF = 16;
  localparam int unsigned VBLANK_LINES_DEF = 20;

  // raster timing strobes handed to the address logic
  typedef struct packed {
    logic       line_start;  // first clock of any scan line
    logic       inc;         // counter advance slot
    logic       line_end;    // last clock of any scan line
    logic       row_line0;   // start of line zero of a displayed row
    logic       last_line;   // current line is the row's last
    logic       frame_start; // start of line zero of row zero
    logic       vblank;      // vertical blanking level
    logic [6:0] row_num;     // current character row
  } dasq_timing_t;

  typedef struct packed {
    logic [9:0] hcnt;
    logic [3:0] line;
    logic [6:0] row;
    logic [7:0] vbcnt;
    logic       vblank;
  } dasq_raster_t;

  typedef struct packed {
    logic [4:0] fields;
    logic       rate;
    logic       en;
  } dasq_blink_t;

endpackage : dasq_pkg

// >>> dasq_raster.sv
// raster counters: characters, scan lines, rows and vertical blanking
// assumes a character clock and live config fields from the register file
`timescale 1ns/1ps
module dasq_raster
  import dasq_pkg::*;
#(
  parameter int unsigned HBLANK_CHARS = HBLANK_CHARS_DEF,
  parameter int unsigned VBLANK_LINES = VBLANK_LINES_DEF
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [7:0]   act_chars,
  input  wire logic [3:0]   lines_m1,
  input  wire logic [6:0]   rows_m1,
  output dasq_timing_t      tim
);

  generate
    if (HBLANK_CHARS < 2 || HBLANK_CHARS > 255 ||
        VBLANK_LINES < 1 || VBLANK_LINES > 256) begin : g_chk
      $error("dasq_raster: blanking parameters out of range");
    end
  endgenerate

  localparam logic [9:0] HBL = 10'(HBLANK_CHARS);
  localparam logic [7:0] VBL = 8'(VBLANK_LINES - 1);

  dasq_raster_t st_q;
  dasq_raster_t st_d;
  logic [9:0]   nchars;
  logic [9:0]   htotal_m1;

  // zero in the count field means 256 characters
  assign nchars    = (act_chars == 8'h00) ? 10'h100 : {2'h0, act_chars};
  assign htotal_m1 = 10'(nchars + HBL - 10'h001);

  // next counter state
  always_comb begin
    st_d = st_q;
    if (st_q.hcnt == htotal_m1) begin
      st_d.hcnt = 10'h000;
      if (st_q.vblank) begin
        if (st_q.vbcnt == VBL) begin
          st_d.vblank = 1'b0;
          st_d.row    = 7'h00; // row count restarts each field
          st_d.line   = 4'h0;
        end else begin
          st_d.vbcnt = 8'(st_q.vbcnt + 8'h01);
        end
      end else if (st_q.line == lines_m1) begin
        st_d.line = 4'h0;
        // row total sampled live; changed only in blanking
        if (st_q.row == rows_m1) begin
          st_d.vblank = 1'b1;
          st_d.vbcnt  = 8'h00;
        end else begin
          st_d.row = 7'(st_q.row + 7'h01);
        end
      end else begin
        st_d.line = 4'(st_q.line + 4'h1);
      end
    end else begin
      st_d.hcnt = 10'(st_q.hcnt + 10'h001);
    end
  end

  // counter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // strobes decoded from the counters
  always_comb begin
    tim.line_start  = (st_q.hcnt == 10'h000);
    tim.line_end    = (st_q.hcnt == htotal_m1);
    tim.inc         = st_q.vblank ||
                      (st_q.hcnt != 10'h000 && st_q.hcnt <= nchars);
    tim.row_line0   = tim.line_start && !st_q.vblank && st_q.line == 4'h0;
    tim.last_line   = !st_q.vblank && st_q.line == lines_m1;
    tim.frame_start = tim.row_line0 && st_q.row == 7'h00;
    tim.vblank      = st_q.vblank;
    tim.row_num     = st_q.row;
  end

endmodule : dasq_raster

// >>> dasq_blink.sv
// cursor blink divider counting fields
// assumes one field_start pulse per field from the raster counters
`timescale 1ns/1ps
module dasq_blink
  import dasq_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic field_start,
  input  wire logic rate_sel,
  input  wire logic blink_en,
  output logic      cursor_vis
);

  dasq_blink_t st_q;
  dasq_blink_t st_d;

  // rate and enable take effect at the next field start
  always_comb begin
    st_d = st_q;
    if (field_start) begin
      st_d.fields = 5'(st_q.fields + 5'h01);
      st_d.rate   = rate_sel;
      st_d.en     = blink_en;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // half period on, half off: 1/16 or 1/32 of field rate
  assign cursor_vis = !st_q.en ||
                      (st_q.rate ? st_q.fields[4] : st_q.fields[3]);

endmodule : dasq_blink

// >>> dasq_sequencer.sv
// display address sequencer top: bus slave, address counter, row latch
// assumes an AHB-Lite master with single word transfers, hclk = char clock
//
// Overview of operation
// - region: 12-bit first address, 4-bit last nibble
// - last address wraps to first address on the next advance, anywhere in the row
// - cursor blinks at 1/16 or 1/32 field rate
// - split row equal sets flag, masked interrupt
// - split update happens at row's line zero
// - blink settings apply within one field
// - frame start loads latch and counter
// - counter advances once per active character
// - later lines reload counter from latch
// - row end copies counter into latch
// - after retrace screen start reloads everything
// - counter wraps from last to first address
// - screen start write redirects the next row
// - vertical blanking free-runs counter for refresh
// - cursor asserted while counter equals cursor outside vertical blanking
// - cursor address readable, writable, incrementable
// - pointer address held for host accesses
// - screen start write clears split flag
// - blinking cursor has half duty cycle
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dasq_sequencer
  import dasq_pkg::*;
#(
  parameter int unsigned HBLANK_CHARS = HBLANK_CHARS_DEF,
  parameter int unsigned VBLANK_LINES = VBLANK_LINES_DEF
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  output logic [ADDR_W-1:0]      disp_addr,
  output logic                   cursor_out,
  output logic                   split_irq
);

  // complete block state
  typedef struct packed {
    logic [7:0]        first_lo;
    logic [7:0]        bounds;
    logic [7:0]        blink_split;
    logic [7:0]        act_chars;
    logic [3:0]        lines_m1;
    logic [6:0]        rows_m1;
    logic              blink_en;
    logic              cur_en;
    logic              split_mask;
    logic [ADDR_W-1:0] screen;
    logic              ss_chg;
    logic [ADDR_W-1:0] cursor;
    logic [ADDR_W-1:0] pointer;
    logic [ADDR_W-1:0] mac;
    logic [ADDR_W-1:0] row_start_latch;
    logic              split;
    logic              cur_out;
    logic              irq;
    logic              pend;
    logic              pend_wr;
    logic [7:0]        pend_addr;
    logic              rdy;
    logic [31:0]       rdata;
  } dasq_state_t;

  dasq_state_t  st_q;
  dasq_state_t  st_d;
  dasq_timing_t tim;
  logic         cursor_vis;
  logic [11:0]  first_addr;
  logic [11:0]  last_addr;
  logic [ADDR_W-1:0] mac_next;
  logic         wr_en;
  logic         split_hit;

  // counter plus one, folding back at the buffer end
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a,
    input logic [11:0]       first,
    input logic [11:0]       last
  );
    logic [ADDR_W-1:0] r;
    if (a[11:0] == last) begin
      r = {a[ADDR_W-1:12], first};
    end else begin
      r = ADDR_W'(a + 1'b1);
    end
    return r;
  endfunction : next_addr

  dasq_raster #(
    .HBLANK_CHARS (HBLANK_CHARS),
    .VBLANK_LINES (VBLANK_LINES)
  ) u_raster (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .act_chars (st_q.act_chars),
    .lines_m1  (st_q.lines_m1),
    .rows_m1   (st_q.rows_m1),
    .tim       (tim)
  );

  dasq_blink u_blink (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .field_start (tim.frame_start),
    .rate_sel    (st_q.blink_split[BSP_RATE]),
    .blink_en    (st_q.blink_en),
    .cursor_vis  (cursor_vis)
  );

  // buffer region bounds; last address ends on a 256-word block
  assign first_addr = {st_q.bounds[3:0], st_q.first_lo};
  assign last_addr  = {st_q.bounds[7:4], 8'hFF};
  assign mac_next   = next_addr(st_q.mac, first_addr, last_addr);
  assign wr_en      = st_q.pend && st_q.pend_wr;
  assign split_hit  = tim.row_line0 &&
                      tim.row_num == st_q.blink_split[6:0];

  // next state: bus slave, registers, addressing
  always_comb begin
    st_d = st_q;

    // address phase accepted; reads get one wait state
    if (st_q.pend) begin
      st_d.pend = 1'b0;
      st_d.rdy  = 1'b1;
    end
    if (hsel && htrans[1] && hready) begin
      st_d.pend      = 1'b1;
      st_d.pend_wr   = hwrite;
      st_d.pend_addr = {haddr[7:2], 2'b00};
      st_d.rdy       = hwrite;
    end

    // read data, loaded in the wait state; unmapped reads give zero
    if (st_q.pend && !st_q.pend_wr) begin
      case (st_q.pend_addr)
        REG_FIRST_LO: st_d.rdata = {24'h0, st_q.first_lo};
        REG_BOUNDS:   st_d.rdata = {24'h0, st_q.bounds};
        REG_BLINK_SP: st_d.rdata = {24'h0, st_q.blink_split};
        REG_CONFIG:   st_d.rdata = {5'h0, st_q.split_mask, st_q.cur_en,
                                    st_q.blink_en, 1'b0, st_q.rows_m1,
                                    4'h0, st_q.lines_m1, st_q.act_chars};
        REG_SCREEN:   st_d.rdata = {18'h0, st_q.screen};
        REG_CURSOR:   st_d.rdata = {18'h0, st_q.cursor};
        REG_POINTER:  st_d.rdata = {18'h0, st_q.pointer};
        REG_STATUS:   st_d.rdata = {17'h0, tim.row_num, 6'h0,
                                    tim.vblank, st_q.split};
        REG_ADDRMON:  st_d.rdata = {2'h0, st_q.row_start_latch, 2'h0, st_q.mac};
        default:      st_d.rdata = 32'h0000_0000;
      endcase
    end

    // register writes in the data phase
    if (wr_en) begin
      case (st_q.pend_addr)
        REG_FIRST_LO: st_d.first_lo = hwdata[7:0];
        REG_BOUNDS:   st_d.bounds = hwdata[7:0];
        REG_BLINK_SP: st_d.blink_split = hwdata[7:0];
        REG_CONFIG: begin
          st_d.act_chars  = hwdata[CFG_ACT_LSB +: 8];
          st_d.lines_m1   = hwdata[CFG_LINES_LSB +: 4];
          st_d.rows_m1    = hwdata[CFG_ROWS_LSB +: 7];
          st_d.blink_en   = hwdata[CFG_BLINK_EN];
          st_d.cur_en     = hwdata[CFG_CUR_EN];
          st_d.split_mask = hwdata[CFG_SPLIT_MSK];
        end
        REG_SCREEN: begin
          st_d.screen = hwdata[ADDR_W-1:0];
          st_d.split  = 1'b0;
        end
        REG_CURSOR:  st_d.cursor = hwdata[ADDR_W-1:0];
        REG_POINTER: st_d.pointer = hwdata[ADDR_W-1:0];
        REG_COMMAND: begin
          if (hwdata[CMD_CUR_INC]) begin
            st_d.cursor = ADDR_W'(st_q.cursor + 1'b1);
          end
        end
        REG_STATUS: begin
          if (hwdata[ST_SPLIT]) begin
            st_d.split = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // row-end latch update; a pending screen start write wins
    if (tim.line_end && tim.last_line) begin
      st_d.ss_chg = 1'b0;
      if (st_q.ss_chg) begin
        st_d.row_start_latch = st_q.screen;
      end else begin
        st_d.row_start_latch = st_q.mac;
      end
    end
    if (tim.frame_start) begin
      st_d.ss_chg = 1'b0;
    end
    // screen start written: redirect next row, set beats clear
    if (wr_en && st_q.pend_addr == REG_SCREEN) begin
      st_d.ss_chg = 1'b1;
    end

    // address counter
    if (tim.frame_start) begin
      st_d.mac = st_q.screen;
      st_d.row_start_latch = st_q.screen;
    end else if (tim.line_start && !tim.vblank) begin
      st_d.mac = st_q.row_start_latch;
    end else if (tim.inc) begin
      st_d.mac = mac_next;
    end

    // split row compare at line zero; set wins over any clear
    if (split_hit) begin
      st_d.split = 1'b1;
    end
    st_d.irq = st_d.split && st_q.split_mask;

    // cursor match on the counter, gated by blink phase
    st_d.cur_out = st_q.cur_en && cursor_vis && !tim.vblank &&
                   st_d.mac == st_q.cursor;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q           <= '0;
      st_q.act_chars <= RST_ACT;
      st_q.lines_m1  <= RST_LINES;
      st_q.rows_m1   <= RST_ROWS;
      st_q.rdy       <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register, hresp tied low
  assign hreadyout  = st_q.rdy;
  assign hrdata     = st_q.rdata;
  assign hresp      = 1'b0;
  assign disp_addr  = st_q.mac;
  assign cursor_out = st_q.cur_out;
  assign split_irq  = st_q.irq;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_frame_load;
    tim.frame_start |=> st_q.mac == $past(st_q.screen) &&
                        st_q.row_start_latch == $past(st_q.screen);
  endproperty
  a_frame_load: assert property (p_frame_load)
    else $error("frame start did not load screen start");

  property p_line_reload;
    tim.line_start && !tim.vblank && !tim.frame_start
      |=> st_q.mac == $past(st_q.row_start_latch);
  endproperty
  a_line_reload: assert property (p_line_reload)
    else $error("line start did not reload from row latch");

  property p_advance;
    tim.inc && !tim.line_start && st_q.mac[11:0] != last_addr
      |=> st_q.mac == ADDR_W'($past(st_q.mac) + 1'b1);
  endproperty
  a_advance: assert property (p_advance)
    else $error("counter did not advance by one");

  property p_wrap;
    tim.inc && !tim.line_start && st_q.mac[11:0] == last_addr
      |=> st_q.mac[11:0] == $past(first_addr) &&
          $stable(st_q.mac[ADDR_W-1:12]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap to first address");

  property p_refresh;
    tim.vblank && !tim.frame_start ##1 tim.vblank
      |-> st_q.mac != $past(st_q.mac);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("counter stalled during vertical blanking");

  property p_row_latch;
    tim.line_end && tim.last_line && !st_q.ss_chg &&
    !(wr_en && st_q.pend_addr == REG_SCREEN)
      |=> st_q.row_start_latch == $past(st_q.mac);
  endproperty
  a_row_latch: assert property (p_row_latch)
    else $error("row latch missed counter at row end");

  property p_redirect;
    wr_en && st_q.pend_addr == REG_SCREEN && !tim.frame_start
      ##1 (!tim.frame_start && !(tim.line_end && tim.last_line)) [*2]
      ##1 tim.line_end && tim.last_line
      |=> st_q.row_start_latch == $past(st_q.screen);
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("screen start write did not redirect row");

  property p_split_set;
    split_hit |=> st_q.split ##1 (st_q.irq == st_q.split_mask);
  endproperty
  a_split_set: assert property (p_split_set)
    else $error("split row match not flagged");

  property p_split_clr;
    wr_en && st_q.pend_addr == REG_SCREEN && !split_hit |=> !st_q.split;
  endproperty
  a_split_clr: assert property (p_split_clr)
    else $error("screen start write left split flag set");

  property p_cursor;
    cursor_out |-> st_q.cur_en && st_q.mac == $past(st_q.cursor);
  endproperty
  a_cursor: assert property (p_cursor)
    else $error("cursor asserted off its address");

  property p_read_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state not one cycle");

  c_wrap:     cover property (p_wrap);
  c_split:    cover property (split_hit && st_q.split_mask);
  c_redirect: cover property (wr_en && st_q.pend_addr == REG_SCREEN
                              && !tim.vblank);
  c_cursor:   cover property (cursor_out);

endmodule : dasq_sequencer

// >>> dasq_ram_model.sv
// display buffer ram model on the far side of the address bus
// assumes addresses are sampled on the character clock
`timescale 1ns/1ps
module dasq_ram_model
  import dasq_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic [ADDR_W-1:0] addr,
  output logic      [7:0]        data
);
  logic [7:0] mem_q [2**ADDR_W];

  // pattern tied to the address, so stale data is visible
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      mem_q[i] = 8'(i) ^ 8'hA5;
    end
  end

  // one clock of access latency, like a synchronous part
  always @(posedge hclk) begin
    data <= mem_q[addr];
  end
endmodule : dasq_ram_model

// >>> dasq_sequencer_tb.sv
// self-checking bench: bus master, read and address scoreboards
// assumes the sequencer as top with short raster parameters
`timescale 1ns/1ps
module dasq_sequencer_tb
  import dasq_pkg::*;
;
  localparam logic [13:0] SCR   = 14'h01FA;
  localparam logic [13:0] CUR_A = 14'h01FC;
  localparam logic [7:0]  RA [6] = '{REG_FIRST_LO, REG_BOUNDS,
    REG_BLINK_SP, REG_SCREEN, REG_CURSOR, REG_POINTER};
  localparam logic [31:0] MK [6] = '{32'hFF, 32'hFF, 32'hFF,
    32'h3FFF, 32'h3FFF, 32'h3FFF};

  logic              hclk, hresetn, hsel, hwrite, hreadyout;
  logic              cursor_out, split_irq, watch;
  logic              dph_rd = 1'b0;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans;
  logic [ADDR_W-1:0] disp_addr;
  logic [ADDR_W-1:0] prv = '0;
  logic [7:0]        ram_q;
  logic [31:0]       eq [$];
  logic [31:0]       mq [$];
  logic [13:0]       jq [$];
  int                n_fail, n_tests, hits, cyc;

  // 200 MHz character clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  dasq_sequencer #(.HBLANK_CHARS(2), .VBLANK_LINES(4)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(), .disp_addr(disp_addr),
    .cursor_out(cursor_out), .split_irq(split_irq));

  dasq_ram_model u_ram (.hclk(hclk), .addr(disp_addr), .data(ram_q));

  task automatic cmp(input logic [31:0] g, e, input string s);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : cmp

  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // one edge, then until the slave is ready
  task automatic wt;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wt

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  // read, noting expected value and mask (mask 0: no check)
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    output logic [31:0] v);
    eq.push_back(e);
    mq.push_back(m);
    xfer(1'b0, a, 32'h0);
    v = hrdata;
  endtask : rd

  // wait for a fresh entry into vertical blanking; the raster may first
  // have to run its counters round after a config change
  task automatic wait_vb;
    logic [31:0] s;
    s = 32'h2;
    for (int i = 0; i < 1000 && s[1]; i++) rd(REG_STATUS, 0, 0, s);
    for (int i = 0; i < 1000 && !s[1]; i++) rd(REG_STATUS, 0, 0, s);
    if (!s[1]) cmp(32'h0, 32'h1, "vblank wait");
  endtask : wait_vb

  // watcher: read data, address jumps, cursor, timeout
  always @(posedge hclk) begin
    if (dph_rd && hreadyout) begin
      if (mq[0] != 0) cmp(hrdata & mq[0], eq[0], "read");
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    if (hreadyout) dph_rd <= hsel & htrans[1] & ~hwrite;
    if (watch && disp_addr !== prv && disp_addr !== prv + 1'b1) begin
      cmp(32'(disp_addr), jq.size() ? 32'(jq.pop_front()) : '1, "jump");
    end
    // buffer model answers one clock after the address
    if (watch) cmp(32'(ram_q), 32'(8'(prv) ^ 8'hA5), "ram");
    if (cursor_out === 1'b1) begin
      hits++;
      cmp(32'(disp_addr), 32'(CUR_A), "cursor");
    end
    prv <= disp_addr;
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      summarize();
    end
  end

  // main sequence
  initial begin
    logic [31:0] r, v;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    watch = 1'b0;
    void'($urandom(79834));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REG_CONFIG, 32'h0017_0B50, '1, v);
    rd(REG_SCREEN, 32'h0, '1, v);
    $display("reset values done");
    // random write and readback, then unmapped and command reads
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      wr(RA[i], r);
      rd(RA[i], r & MK[i], '1, v);
    end
    r = $urandom;
    wr(8'h3C, r);
    rd(8'h3C, 32'h0, '1, v);
    rd(REG_COMMAND, 32'h0, '1, v);
    $display("register access done");
    wr(REG_CURSOR, 32'h3FFF);
    wr(REG_COMMAND, 32'h1);
    rd(REG_CURSOR, 32'h0, '1, v);
    $display("cursor increment done");
    // 4 chars, 2 lines, 3 rows; wrap 0x1FF to 0x040; split row 1
    wr(REG_CONFIG, 32'h0602_0104); // first frame after it is discarded
    wr(REG_FIRST_LO, 32'h40);
    wr(REG_BOUNDS, 32'h10);
    wr(REG_BLINK_SP, 32'h1);
    wr(REG_SCREEN, 32'(SCR)); // frames ahead of use
    wr(REG_CURSOR, 32'(CUR_A)); // set long before it applies
    wait_vb();
    jq = '{SCR, SCR, 14'h040, 14'h1FE, 14'h040, 14'h042, SCR};
    watch <= 1'b1;
    for (int i = 0; i < 300 && jq.size() != 0; i++) @(posedge hclk);
    watch <= 1'b0;
    cmp(32'(jq.size()), 32'h0, "frame jumps");
    $display("frame addressing done");
    wait_vb();
    rd(REG_STATUS, 32'h1, 32'h1, v);
    cmp(32'(split_irq), 32'h1, "irq set");
    wr(REG_SCREEN, 32'(SCR));
    rd(REG_STATUS, 32'h0, 32'h1, v);
    cmp(32'(split_irq), 32'h0, "irq clear");
    cmp(32'(hits != 0), 32'h1, "cursor seen");
    $display("split and cursor done");
    summarize();
  end
endmodule : dasq_sequencer_tb
